/* hw/fzmc_core.sv */
// Float compare, float zone compare and matrix bit search unit with APB slave
`timescale 1ns/1ns
`default_nettype none
`include "fzmc_cfg.svh"
module fzmc_core
  import fzmc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        scan_strobe,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  result_bits,
  output logic             global_error,
  output logic             search_busy
);

  fzmc_state_t st_r;
  fzmc_state_t st_nxt;

  logic        g12;
  logic        l12;
  logic        e12;
  logic        b12;
  logic        gv1;
  logic        lv1;
  logic        ev1;
  logic        bv1;
  logic        gv2;
  logic        lv2;
  logic        ev2;
  logic        bv2;
  logic        fire;
  logic        dest_bad;
  logic        len_bad;
  logic        ptr_bad;
  logic [12:0] last13;
  logic        bit_eq;
  logic        qual;
  logic        at_last;
  logic        acc;
  logic        wr;
  logic [31:0] rd_word;
  logic        mapped;
  logic        is_ctrl;
  logic [2:0]  zone_res;
  logic [2:0]  float_compare_res;
  logic [31:0] status_w;

  fzmc_fp_cmp u_cmp12 (.a(st_r.opa), .b(st_r.opb), .gt(g12), .lt(l12), .eq(e12), .bad(b12));
  fzmc_fp_cmp u_cmpv1 (.a(st_r.opv), .b(st_r.opa), .gt(gv1), .lt(lv1), .eq(ev1), .bad(bv1));
  fzmc_fp_cmp u_cmpv2 (.a(st_r.opv), .b(st_r.opb), .gt(gv2), .lt(lv2), .eq(ev2), .bad(bv2));

  // Pulse mode sees only a rising condition between scans
  assign fire     = scan_strobe & st_r.cond & (~st_r.pulse | ~st_r.cond_prev) & (st_r.phase == FZMC_IDLE);
  assign dest_bad = ({1'b0, st_r.dest} + `FZMC_DEST_SPAN) > `FZMC_DEST_LAST;
  assign len_bad  = (st_r.len < `FZMC_LEN_MIN) | (st_r.len > `FZMC_LEN_MAX);
  assign last13   = {st_r.len[8:0], 4'h0} - 13'h0001;
  assign ptr_bad  = st_r.ptr > {3'h0, last13};
  assign bit_eq   = st_r.mat_a[st_r.idx[11:4]][st_r.idx[3:0]] == st_r.mat_b[st_r.idx[11:4]][st_r.idx[3:0]];
  assign qual     = st_r.polar ? bit_eq : ~bit_eq;
  assign at_last  = st_r.idx == st_r.last;
  assign float_compare_res = {l12, e12, g12};
  // Swapped bounds collapse to the first bound
  assign zone_res = g12 ? {gv1, ev1, lv1} : {gv2, ~lv1 & ~gv2, lv1};
  assign status_w = {23'h000000, st_r.phase == FZMC_SEARCH, st_r.gerr, st_r.perr, st_r.match,
                     st_r.restart, st_r.eom, st_r.result};
  assign acc      = psel & penable;
  assign wr       = acc & st_r.pready & pwrite;
  assign is_ctrl  = paddr[11:6] == 6'h00;

  always_comb
  begin
    mapped  = 1'b1;
    rd_word = 32'h00000000;
    if (paddr[11:10] == `FZMC_WIN_MAT_A)
      rd_word = {16'h0000, st_r.mat_a[paddr[9:2]]};
    else if (paddr[11:10] == `FZMC_WIN_MAT_B)
      rd_word = {16'h0000, st_r.mat_b[paddr[9:2]]};
    else if (is_ctrl)
    begin
      case (paddr)
        `FZMC_OFS_CTRL:    rd_word = {27'h0000000, st_r.polar, st_r.pulse, st_r.cond, st_r.op};
        `FZMC_OFS_OPA:     rd_word = st_r.opa;
        `FZMC_OFS_OPB:     rd_word = st_r.opb;
        `FZMC_OFS_OPV:     rd_word = st_r.opv;
        `FZMC_OFS_LEN:     rd_word = {16'h0000, st_r.len};
        `FZMC_OFS_PTR:     rd_word = {16'h0000, st_r.ptr};
        `FZMC_OFS_DEST:    rd_word = {16'h0000, st_r.dest};
        `FZMC_OFS_STATUS:  rd_word = status_w;
        `FZMC_OFS_ERRCODE: rd_word = {16'h0000, st_r.errcode};
        default:           mapped  = 1'b0;
      endcase
    end
    else
      mapped = 1'b0;
  end

  always_comb
  begin
    st_nxt = st_r;
    // One wait state so that pready and prdata both leave flops
    st_nxt.pready = acc & ~st_r.pready;
    if (acc & ~st_r.pready)
    begin
      st_nxt.prdata  = pwrite ? 32'h00000000 : rd_word;
      st_nxt.pslverr = ~mapped;
    end
    if (wr & mapped)
    begin
      if (paddr[11:10] == `FZMC_WIN_MAT_A)
        st_nxt.mat_a[paddr[9:2]] = pwdata[15:0];
      else if (paddr[11:10] == `FZMC_WIN_MAT_B)
        st_nxt.mat_b[paddr[9:2]] = pwdata[15:0];
      else
      begin
        case (paddr)
          `FZMC_OFS_CTRL:
          begin
            st_nxt.op    = fzmc_op_t'(pwdata[`FZMC_CTRL_OP_LSB +: 2]);
            st_nxt.cond  = pwdata[`FZMC_CTRL_COND];
            st_nxt.pulse = pwdata[`FZMC_CTRL_PULSE];
            st_nxt.polar = pwdata[`FZMC_CTRL_POLAR];
          end
          `FZMC_OFS_OPA:     st_nxt.opa     = pwdata;
          `FZMC_OFS_OPB:     st_nxt.opb     = pwdata;
          `FZMC_OFS_OPV:     st_nxt.opv     = pwdata;
          `FZMC_OFS_LEN:     st_nxt.len     = pwdata[15:0];
          `FZMC_OFS_PTR:     st_nxt.ptr     = pwdata[15:0];
          `FZMC_OFS_DEST:    st_nxt.dest    = pwdata[15:0];
          `FZMC_OFS_ERRCODE: st_nxt.errcode = pwdata[15:0];
          `FZMC_OFS_STATUS:
          begin
            if (pwdata[`FZMC_ST_GERR])
              st_nxt.gerr = 1'b0;
            if (pwdata[`FZMC_ST_PERR])
              st_nxt.perr = 1'b0;
          end
          default:           st_nxt.op      = st_r.op;
        endcase
      end
    end
    if (scan_strobe)
      st_nxt.cond_prev = st_r.cond;
    // Execution comes after the bus so a hardware set beats a clear
    case (st_r.phase)
      FZMC_IDLE:
      begin
        if (fire)
        begin
          case (st_r.op)
            FZMC_OP_FLOAT_COMPARE, FZMC_OP_ZONE:
            begin
              if (dest_bad)
              begin
                st_nxt.gerr    = 1'b1;
                st_nxt.errcode = `FZMC_ERR_DEST;
              end
              else if (b12 | ((st_r.op == FZMC_OP_ZONE) & bv1))
              begin
                st_nxt.result  = 3'h0;
                st_nxt.gerr    = 1'b1;
                st_nxt.errcode = `FZMC_ERR_FLOAT;
              end
              else
                st_nxt.result = (st_r.op == FZMC_OP_ZONE) ? zone_res : float_compare_res;
            end
            FZMC_OP_MAT:
            begin
              if (len_bad)
              begin
                st_nxt.gerr    = 1'b1;
                st_nxt.errcode = `FZMC_ERR_LEN;
              end
              else if (ptr_bad)
                st_nxt.perr = 1'b1;
              else
              begin
                st_nxt.perr  = 1'b0;
                st_nxt.match = 1'b0;
                st_nxt.eom   = 1'b0;
                st_nxt.last  = last13[11:0];
                st_nxt.phase = FZMC_SEARCH;
                // Pointer already on the last bit wraps like an end
                if (st_r.restart | (st_r.ptr == {3'h0, last13}))
                  st_nxt.idx = 12'h000;
                else
                  st_nxt.idx = st_r.ptr[11:0] + 12'h001;
              end
            end
            default:
              st_nxt.phase = FZMC_IDLE;
          endcase
        end
      end
      FZMC_SEARCH:
      begin
        // One bit per cycle; a full 4096-bit sweep takes 4096 cycles
        if (qual | at_last)
        begin
          st_nxt.ptr     = {4'h0, st_r.idx};
          st_nxt.match   = qual;
          st_nxt.eom     = at_last;
          st_nxt.restart = at_last;
          st_nxt.phase   = FZMC_IDLE;
        end
        else
          st_nxt.idx = st_r.idx + 12'h001;
      end
      default:
        st_nxt.phase = FZMC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= `FZMC_STATE_RST;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign prdata       = st_r.prdata;
  assign pready       = st_r.pready;
  assign pslverr      = st_r.pslverr;
  assign result_bits  = st_r.result;
  assign global_error = st_r.gerr;
  assign search_busy  = st_r.phase == FZMC_SEARCH;

  logic go_f;
  logic go_z;
  logic go_m;
  assign go_f = clk_en & fire & (st_r.op == FZMC_OP_FLOAT_COMPARE) & ~dest_bad & ~b12;
  assign go_z = clk_en & fire & (st_r.op == FZMC_OP_ZONE) & ~dest_bad & ~b12 & ~bv1;
  assign go_m = clk_en & fire & (st_r.op == FZMC_OP_MAT);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  float_compare_greater_a: assert property (go_f & g12 |=> result_bits == 3'b001)
    else $error("float greater did not set bit0");
  result_onehot_a: assert property (go_f | go_z |=> $onehot(result_bits))
    else $error("result not one-hot");
  cond_hold_a: assert property (clk_en & ~fire & ~search_busy |=> result_bits == $past(result_bits))
    else $error("result changed without execution");
  float_range_a: assert property (clk_en & fire & (st_r.op == FZMC_OP_FLOAT_COMPARE) & ~dest_bad & b12
                                  |=> result_bits == 3'b000 && global_error && st_r.errcode == 16'h2013)
    else $error("range error not reported");
  dest_range_a: assert property (clk_en & fire & (st_r.op != FZMC_OP_MAT) & (st_r.op != FZMC_OP_NONE)
                                 & dest_bad |=> st_r.errcode == 16'h2003 && result_bits == $past(result_bits))
    else $error("destination error not reported");
  zone_above_a: assert property (go_z & ~g12 & gv2 |=> result_bits == 3'b100)
    else $error("zone above not flagged");
  zone_swap_a: assert property (go_z & g12 & ev1 |=> result_bits == 3'b010)
    else $error("swapped bounds mishandled");
  zone_inside_a: assert property (go_z & ~g12 & ~lv1 & ~gv2 |=> result_bits == 3'b010)
    else $error("zone inside not flagged");
  len_check_a: assert property (go_m & len_bad |=> !search_busy && st_r.errcode == 16'h200b && global_error)
    else $error("bad length accepted");
  ptr_check_a: assert property (go_m & ~len_bad & ptr_bad |=> st_r.perr && !search_busy)
    else $error("bad pointer accepted");
  search_hit_a: assert property (clk_en & search_busy & qual
                                 |=> !search_busy && st_r.match && st_r.ptr == {4'h0, $past(st_r.idx)})
    else $error("hit not reported");
  matrix_end_a: assert property (clk_en & search_busy & at_last
                                 |=> st_r.eom && st_r.restart && st_r.match == $past(qual))
    else $error("end of matrix not reported");
  start_pos_a: assert property (go_m & ~len_bad & ~ptr_bad & ~st_r.restart & (st_r.ptr != {3'h0, last13})
                                |=> search_busy && st_r.idx == $past(st_r.ptr[11:0]) + 12'h001)
    else $error("search started at wrong bit");
  pulse_once_a: assert property (clk_en & scan_strobe & st_r.pulse & st_r.cond & st_r.cond_prev
                                 |=> result_bits == $past(result_bits))
    else $error("pulse mode executed twice");
  float_compare_equal_a: assert property (go_f & e12 |=> result_bits == 3'b010)
    else $error("float equal did not set bit1");
  float_compare_less_a: assert property (go_f & l12 |=> result_bits == 3'b100)
    else $error("float less did not set bit2");
  zone_below_a: assert property (go_z & ~g12 & lv1 |=> result_bits == 3'b001)
    else $error("zone below not flagged");
  zone_range_a: assert property (clk_en & fire & (st_r.op == FZMC_OP_ZONE) & ~dest_bad & ~b12 & bv1
                                 |=> result_bits == 3'b000 && global_error && st_r.errcode == 16'h2013)
    else $error("zone range error not reported");
  cond_low_a: assert property (clk_en & scan_strobe & ~st_r.cond & ~search_busy
                               |=> !search_busy && result_bits == $past(result_bits))
    else $error("executed with condition false");
  len_max_a: assert property (go_m & (st_r.len == `FZMC_LEN_MAX) & ~ptr_bad |=> search_busy)
    else $error("full length refused");
  last_bit_a: assert property (go_m & ~len_bad & ~ptr_bad
                               |=> st_r.last == $past(last13[11:0]))
    else $error("last bit not sixteen times length minus one");
  restart_start_a: assert property (go_m & ~len_bad & ~ptr_bad & st_r.restart
                                    |=> search_busy && st_r.idx == 12'h000)
    else $error("restart did not begin at bit 0");
  search_step_a: assert property (clk_en & search_busy & ~qual & ~at_last
                                  |=> search_busy && st_r.idx == $past(st_r.idx) + 12'h001)
    else $error("search skipped a bit");
  polar_equal_a: assert property (clk_en & search_busy & st_r.polar & bit_eq |=> st_r.match)
    else $error("equal bit missed");
  polar_differ_a: assert property (clk_en & search_busy & ~st_r.polar & ~bit_eq |=> st_r.match)
    else $error("differing bit missed");
  ptr_end_a: assert property (clk_en & search_busy & at_last
                              |=> st_r.ptr == {4'h0, $past(st_r.idx)})
    else $error("last bit number not stored");
  // Sticky until software clears it; a same-cycle set wins
  gerr_sticky_a: assert property (clk_en & global_error & ~(wr & (paddr == `FZMC_OFS_STATUS))
                                  |=> global_error)
    else $error("error flag dropped");

  hit_seen_c: cover property (clk_en & search_busy & qual & ~at_last);
  end_seen_c: cover property (clk_en & search_busy & at_last);
  zone_run_c: cover property (go_z ##1 result_bits == 3'b010);
  err_seen_c: cover property (go_m & len_bad);
  swap_run_c: cover property (go_z & g12);

endmodule : fzmc_core
`default_nettype wire

/* hw/fzmc_cfg.svh */
// Register offsets, field positions, error codes and limits of the compare unit
`ifndef FZMC_CFG_SVH
`define FZMC_CFG_SVH

`define FZMC_ADDR_W        12
`define FZMC_OFS_CTRL      12'h000
`define FZMC_OFS_OPA       12'h004
`define FZMC_OFS_OPB       12'h008
`define FZMC_OFS_OPV       12'h00c
`define FZMC_OFS_LEN       12'h010
`define FZMC_OFS_PTR       12'h014
`define FZMC_OFS_DEST      12'h018
`define FZMC_OFS_STATUS    12'h01c
`define FZMC_OFS_ERRCODE   12'h020
`define FZMC_WIN_MAT_A     2'b01
`define FZMC_WIN_MAT_B     2'b10

`define FZMC_CTRL_OP_LSB   0
`define FZMC_CTRL_COND     2
`define FZMC_CTRL_PULSE    3
`define FZMC_CTRL_POLAR    4

`define FZMC_ST_EOM        3
`define FZMC_ST_RESTART    4
`define FZMC_ST_MATCH      5
`define FZMC_ST_PERR       6
`define FZMC_ST_GERR       7
`define FZMC_ST_BUSY       8

`define FZMC_ERR_DEST      16'h2003
`define FZMC_ERR_LEN       16'h200b
`define FZMC_ERR_FLOAT     16'h2013

`define FZMC_LEN_MIN       16'h0001
`define FZMC_LEN_MAX       16'h0100
`define FZMC_DEST_LAST     17'h01fff
`define FZMC_DEST_SPAN     17'h00002
`define FZMC_STATE_RST     '0

`endif

/* hw/fzmc_pkg.sv */
// Types shared by the compare unit
package fzmc_pkg;

  typedef enum logic [1:0] {
    FZMC_OP_FLOAT_COMPARE = 2'b00,
    FZMC_OP_ZONE = 2'b01,
    FZMC_OP_MAT  = 2'b10,
    FZMC_OP_NONE = 2'b11
  } fzmc_op_t;

  typedef enum logic {
    FZMC_IDLE   = 1'b0,
    FZMC_SEARCH = 1'b1
  } fzmc_phase_t;

  typedef struct packed {
    fzmc_op_t              op;
    logic                  cond;
    logic                  pulse;
    logic                  polar;
    logic                  cond_prev;
    fzmc_phase_t           phase;
    logic [31:0]           opa;
    logic [31:0]           opb;
    logic [31:0]           opv;
    logic [15:0]           len;
    logic [15:0]           ptr;
    logic [15:0]           dest;
    logic [2:0]            result;
    logic                  eom;
    logic                  restart;
    logic                  match;
    logic                  perr;
    logic                  gerr;
    logic [15:0]           errcode;
    logic [11:0]           idx;
    logic [11:0]           last;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [255:0][15:0]    mat_a;
    logic [255:0][15:0]    mat_b;
  } fzmc_state_t;

endpackage : fzmc_pkg

/* hw/fzmc_fp_cmp.sv */
// Single-precision magnitude/sign compare with range check
`timescale 1ns/1ns
`default_nettype none
module fzmc_fp_cmp
  import fzmc_pkg::*;
(
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic             gt,
  output logic             lt,
  output logic             eq,
  output logic             bad
);

  logic        a_zero;
  logic        b_zero;
  logic        mag_gt;
  logic        mag_eq;

  // All-ones exponent is infinity or NaN, outside the usable range
  assign bad    = (a[30:23] == 8'hff) | (b[30:23] == 8'hff);
  assign a_zero = (a[30:0] == 31'h00000000);
  assign b_zero = (b[30:0] == 31'h00000000);
  assign mag_gt = a[30:0] > b[30:0];
  assign mag_eq = a[30:0] == b[30:0];

  always_comb
  begin
    gt = 1'b0;
    lt = 1'b0;
    eq = 1'b0;
    // Signed zeros compare equal
    if ((a_zero & b_zero) | (mag_eq & (a[31] == b[31])))
      eq = 1'b1;
    else if (a[31] != b[31])
    begin
      gt = ~a[31];
      lt = a[31];
    end
    else if (a[31])
    begin
      gt = ~mag_gt;
      lt = mag_gt;
    end
    else
    begin
      gt = mag_gt;
      lt = ~mag_gt;
    end
  end

endmodule : fzmc_fp_cmp
`default_nettype wire

/* sim/test_float_zone_matrix_compare.sv */
// Self-checking bench of the float, zone and matrix compare unit
`timescale 1ns/1ns
`default_nettype none
`include "fzmc_cfg.svh"
module test_float_zone_matrix_compare
  import fzmc_pkg::*;
;
  logic        clk_sys     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        clk_en      = 1'b1;
  logic        scan_strobe = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  result_bits;
  logic        global_error;
  logic        search_busy;
  logic [31:0] rv;
  logic        re;
  logic        busy_seen;
  int          err_total   = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;

  fzmc_core dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .scan_strobe(scan_strobe),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .result_bits(result_bits),
    .global_error(global_error), .search_busy(search_busy)
  );

  always #2 clk_sys = ~clk_sys;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Ceiling far above the several hundred cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Sampling at the edge sees pre-edge register values, as the protocol wants
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic ctrl(input fzmc_op_t op, input logic cond, input logic pulse, input logic polar);
    wr(`FZMC_OFS_CTRL, {27'h0, polar, pulse, cond, op});
  endtask : ctrl

  task automatic clr();
    wr(`FZMC_OFS_STATUS, 32'h0000_00c0);
    wr(`FZMC_OFS_ERRCODE, 32'h0);
  endtask : clr

  // One scan strobe, then wait out any matrix search
  task automatic exec();
    @(posedge clk_sys);
    scan_strobe <= 1'b1;
    @(posedge clk_sys);
    scan_strobe <= 1'b0;
    @(negedge clk_sys);
    busy_seen = search_busy;
    // Pointer left alone until the search is over
    while (search_busy !== 1'b0)
    begin
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
  endtask : exec

  task automatic t_reset();
    chk("reset result", 32'h0, {29'h0, result_bits});
    rd(`FZMC_OFS_STATUS);
    chk("reset status", 32'h0, rv);
    rd(12'h300);
    chk("unmapped slverr", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, rv);
  endtask : t_reset

  task automatic t_float_compare();
    logic [31:0] oa[3] = '{32'h4000_0000, 32'h3f80_0000, 32'hbf80_0000};
    logic [31:0] ex[3] = '{32'h1, 32'h2, 32'h4};
    wr(`FZMC_OFS_DEST, 32'h0000_1ffd);
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b1, 1'b0, 1'b0);
    wr(`FZMC_OFS_OPB, 32'h3f80_0000);
    for (int i = 0; i < 3; i++)
    begin
      wr(`FZMC_OFS_OPA, oa[i]);
      exec();
      chk("float_compare result", ex[i], {29'h0, result_bits});
    end
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b0, 1'b0, 1'b0);
    wr(`FZMC_OFS_OPA, 32'h4000_0000);
    exec();
    chk("held result", 32'h4, {29'h0, result_bits});
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b1, 1'b0, 1'b0);
    wr(`FZMC_OFS_DEST, 32'h0000_1ffe);
    exec();
    chk("dest skip result", 32'h4, {29'h0, result_bits});
    chk("dest gerr", 32'h1, {31'h0, global_error});
    rd(`FZMC_OFS_ERRCODE);
    chk("dest code", 32'h2003, rv);
    clr();
    chk("gerr cleared", 32'h0, {31'h0, global_error});
    wr(`FZMC_OFS_DEST, 32'h0);
    wr(`FZMC_OFS_OPB, 32'h7f80_0000);
    exec();
    chk("inf result", 32'h0, {29'h0, result_bits});
    chk("inf gerr", 32'h1, {31'h0, global_error});
    rd(`FZMC_OFS_ERRCODE);
    chk("inf code", 32'h2013, rv);
    clr();
  endtask : t_float_compare

  task automatic t_zone();
    logic [31:0] z[7][3] = '{
      '{32'h3f80_0000, 32'h4040_0000, 32'hbf80_0000}, '{32'h3f80_0000, 32'h4040_0000, 32'h3f80_0000},
      '{32'h3f80_0000, 32'h4040_0000, 32'h4040_0000}, '{32'h3f80_0000, 32'h4040_0000, 32'h4080_0000},
      '{32'h4040_0000, 32'h3f80_0000, 32'h4000_0000}, '{32'h4040_0000, 32'h3f80_0000, 32'h4040_0000},
      '{32'h4040_0000, 32'h3f80_0000, 32'h4080_0000}};
    logic [2:0] ze[7] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4};
    ctrl(FZMC_OP_ZONE, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      wr(`FZMC_OFS_OPA, z[i][0]);
      wr(`FZMC_OFS_OPB, z[i][1]);
      wr(`FZMC_OFS_OPV, z[i][2]);
      exec();
      chk("zone result", {29'h0, ze[i]}, {29'h0, result_bits});
    end
    wr(`FZMC_OFS_OPV, 32'hff80_0000);
    exec();
    rd(`FZMC_OFS_ERRCODE);
    chk("zone inf code", 32'h2013, rv);
    clr();
  endtask : t_zone

  // Differing bits 1, 5 and 45 across three words
  task automatic t_mat();
    logic [31:0] ep[4] = '{32'd5, 32'd45, 32'd47, 32'd1};
    logic [31:0] es[4] = '{32'h20, 32'h20, 32'h18, 32'h20};
    logic [31:0] bl[2] = '{32'h0, 32'h101};
    wr(`FZMC_OFS_LEN, 32'h3);
    wr(12'h400, 32'h0022);
    wr(12'h404, 32'h1234);
    wr(12'h804, 32'h1234);
    wr(12'h408, 32'h2000);
    wr(`FZMC_OFS_PTR, 32'h2);
    ctrl(FZMC_OP_MAT, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      exec();
      rd(`FZMC_OFS_PTR);
      chk("search ptr", ep[i], rv);
      rd(`FZMC_OFS_STATUS);
      chk("search flags", es[i], rv & 32'h38);
    end
    ctrl(FZMC_OP_MAT, 1'b1, 1'b0, 1'b1);
    wr(`FZMC_OFS_PTR, 32'h0);
    exec();
    rd(`FZMC_OFS_PTR);
    chk("equal search ptr", 32'h2, rv);
    ctrl(FZMC_OP_MAT, 1'b1, 1'b0, 1'b0);
    wr(12'h408, 32'ha000);
    wr(`FZMC_OFS_PTR, 32'd46);
    exec();
    rd(`FZMC_OFS_PTR);
    chk("last bit ptr", 32'd47, rv);
    rd(`FZMC_OFS_STATUS);
    chk("match and end", 32'h28, rv & 32'h28);
    wr(`FZMC_OFS_PTR, 32'd48);
    exec();
    chk("ptr error idle", 32'h0, {31'h0, busy_seen});
    rd(`FZMC_OFS_STATUS);
    chk("ptr error", 32'h40, rv & 32'h40);
    rd(`FZMC_OFS_PTR);
    chk("ptr kept", 32'd48, rv);
    clr();
    wr(`FZMC_OFS_LEN, 32'h100);
    // Restart left by the earlier end still pends
    exec();
    rd(`FZMC_OFS_PTR);
    chk("restart ptr", 32'd1, rv);
    wr(`FZMC_OFS_PTR, 32'd4000);
    exec();
    chk("full length busy", 32'h1, {31'h0, busy_seen});
    rd(`FZMC_OFS_PTR);
    chk("full length ptr", 32'd4095, rv);
    rd(`FZMC_OFS_STATUS);
    chk("full length flags", 32'h08, rv & 32'hc8);
    wr(`FZMC_OFS_PTR, 32'd4096);
    exec();
    rd(`FZMC_OFS_STATUS);
    chk("ptr 4096 error", 32'h40, rv & 32'h40);
    clr();
    foreach (bl[i])
    begin
      wr(`FZMC_OFS_LEN, bl[i]);
      wr(`FZMC_OFS_PTR, 32'h5);
      exec();
      rd(`FZMC_OFS_PTR);
      chk("len skip ptr", 32'h5, rv);
      rd(`FZMC_OFS_ERRCODE);
      chk("len code", 32'h200b, rv);
      chk("len gerr", 32'h1, {31'h0, global_error});
      clr();
    end
  endtask : t_mat

  task automatic t_pulse();
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b0, 1'b1, 1'b0);
    exec();
    wr(`FZMC_OFS_OPA, 32'h3f80_0000);
    wr(`FZMC_OFS_OPB, 32'h4000_0000);
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b1, 1'b1, 1'b0);
    exec();
    chk("pulse first", 32'h4, {29'h0, result_bits});
    wr(`FZMC_OFS_OPA, 32'h4040_0000);
    exec();
    chk("pulse level held", 32'h4, {29'h0, result_bits});
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b0, 1'b1, 1'b0);
    exec();
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b1, 1'b1, 1'b0);
    exec();
    chk("pulse second edge", 32'h1, {29'h0, result_bits});
    ctrl(FZMC_OP_NONE, 1'b1, 1'b0, 1'b0);
    exec();
    chk("none op held", 32'h1, {29'h0, result_bits});
    wr(`FZMC_OFS_OPA, 32'h3f80_0000);
    ctrl(FZMC_OP_FLOAT_COMPARE, 1'b1, 1'b0, 1'b0);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    exec();
    chk("frozen result", 32'h1, {29'h0, result_bits});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    exec();
    chk("thawed result", 32'h4, {29'h0, result_bits});
  endtask : t_pulse

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_float_compare();
    t_zone();
    t_mat();
    t_pulse();
    wrap_up();
  end
endmodule : test_float_zone_matrix_compare
`default_nettype wire
